// >>> hw/fbr_cfg.svh
// Behaviour
// RULE1 - Each instruction fetch returns four bytes of array data in one clock.
// RULE2 - The array holds four blocks on the large variant or two on the small, and erase and program act on whole blocks; here program writes one word.
// RULE3 - One chip erase clears every block of the array together.
// RULE4 - While self programming runs, fetch and data access to the array are blocked, so the rewrite code lives in RAM or external memory.
// RULE5 - Interrupts are still taken and serviced while a self-programming rewrite runs.
// RULE6 - In programming mode the external programmer issues erase and write operations over the serial link.
// RULE7 - The external programmer may rewrite the array with the device already mounted on the board.
// RULE8 - A security setting, once made, refuses rewriting of the user program; here block erase and program are refused in prog mode only.
// RULE9 - On the large variant a boot swap lets self programming rewrite the whole array, boot area included.
// RULE10 - Once chip erase is prohibited that prohibition is permanent, since only chip erase could clear it; here reset still clears it.
`ifndef FBR_CFG_SVH
`define FBR_CFG_SVH
`define FBR_ERASED_WORD 32'hFFFFFFFF
`define FBR_BUSY_CYCLES 8'h10
`define FBR_LAST_CNT    8'h01
`define FBR_CNT_STEP    8'h01
`define FBR_SEC_BLKERA  0
`define FBR_SEC_CHPERA  1
`define FBR_SEC_PROG    2
`endif

// >>> hw/fbr_pkg.sv
// ****************************************
// command and state types
// ****************************************
package fbr_pkg;
	typedef enum logic [2:0] {
		FBR_CMD_NONE  = 3'b000,
		FBR_CMD_BERA  = 3'b001,
		FBR_CMD_CERA  = 3'b010,
		FBR_CMD_PROG  = 3'b011,
		FBR_CMD_SECUR = 3'b100,
		FBR_CMD_SWAP  = 3'b101
	} fbr_cmd_t;
	typedef enum logic [1:0] {
		FBR_ST_IDLE = 2'b00,
		FBR_ST_BUSY = 2'b01,
		FBR_ST_DONE = 2'b10
	} fbr_state_t;
endpackage : fbr_pkg

// >>> hw/fbr_ctrl.sv
`timescale 1ns/1ps
`include "fbr_cfg.svh"
// ****************************************
// flash array, fetch port and rewrite sequencer
// ****************************************
module fbr_ctrl #(
	parameter int BLOCKS      = 4,
	parameter int BLK_WORDS   = 16,
	parameter bit LARGE_VAR   = 1'b1
) (
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic              fetch_req_i,
	input  wire logic [15:0]       fetch_addr_i,
	output logic      [31:0]       fetch_data_o,
	output logic                   fetch_ok_o,
	input  wire logic              prog_mode_i,
	input  wire logic              self_mode_i,
	input  wire logic              cmd_valid_i,
	input  wire fbr_pkg::fbr_cmd_t cmd_i,
	input  wire logic [15:0]       cmd_addr_i,
	input  wire logic [31:0]       cmd_data_i,
	input  wire logic              irq_req_i,
	output logic                   irq_ack_o,
	output logic                   busy_o,
	output logic                   done_o,
	output logic                   refused_o,
	output logic [2:0]             sec_o,
	output logic                   swap_o
);
	import fbr_pkg::*;
	localparam int AW = $clog2(BLOCKS * BLK_WORDS);
	localparam int BW = $clog2(BLOCKS);
	logic [31:0] mem_r [BLOCKS * BLK_WORDS];
	fbr_state_t  st_r, st_nxt;
	fbr_cmd_t    op_r, op_nxt;
	logic [AW-1:0] ad_r, ad_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [7:0]  cnt_r, cnt_nxt;
	logic [2:0]    sec_r;          // security bits as held
	logic [2:0]    sec_nxt;        // security bits after a command
	logic [2:0]    lock_nxt;       // security bits with the sticky lock applied
	logic          swap_r;         // boot swap state
	logic          swap_nxt;
	logic          self_r;         // running operation came from self programming
	logic          self_nxt;
	logic          ref_nxt;        // refusal pulse
	logic          ok_nxt;         // fetch served next cycle
	logic          busy_nxt;
	logic          done_nxt;
	logic          ack_nxt;        // interrupt acknowledge
	logic [31:0]   fd_nxt;         // raw word read from the array
	logic [31:0]   fdo_nxt;        // word as presented on the fetch port
	logic          lvl_ok;         // prog mode, or self mode on the large variant, is active
	logic          last_cyc;       // final cycle of a timed operation

	// ****************************************
	// end of a timed operation
	// ****************************************
	// one decode shared by the sequencer and the array update, so both agree
	assign last_cyc = (st_r == FBR_ST_BUSY) && (cnt_r == `FBR_LAST_CNT);
	// ****************************************
	// command acceptance and sequencing
	// ****************************************
	always_comb begin
		st_nxt   = st_r;
		op_nxt   = op_r;
		ad_nxt   = ad_r;
		wd_nxt   = wd_r;
		cnt_nxt  = cnt_r;
		sec_nxt  = sec_r;
		swap_nxt = swap_r;
		self_nxt = self_r;
		ref_nxt  = 1'b0;
		// RULE6 programmer link in prog mode, plus self mode on the large variant (RULE7 no off-board restriction)
		lvl_ok   = prog_mode_i | (self_mode_i & LARGE_VAR);
		case (st_r)
			FBR_ST_IDLE: begin
				if (cmd_valid_i && lvl_ok) begin
					op_nxt = cmd_i;
					ad_nxt = cmd_addr_i[AW-1:0];
					wd_nxt = cmd_data_i;
					cnt_nxt = `FBR_BUSY_CYCLES;
					self_nxt = ~prog_mode_i;
					st_nxt = FBR_ST_BUSY;
					case (cmd_i)
						// RULE8 security refuses rewrites from the programmer
						FBR_CMD_BERA: if (prog_mode_i && (sec_r[`FBR_SEC_BLKERA]
							|| sec_r[`FBR_SEC_CHPERA] || sec_r[`FBR_SEC_PROG]))
							st_nxt = FBR_ST_IDLE;
						// RULE3 chip erase is programmer only
						FBR_CMD_CERA: if (!prog_mode_i || sec_r[`FBR_SEC_CHPERA])
							st_nxt = FBR_ST_IDLE;
						FBR_CMD_PROG: if (prog_mode_i && sec_r[`FBR_SEC_PROG])
							st_nxt = FBR_ST_IDLE;
						// self programming may only tighten security
						FBR_CMD_SECUR: begin
							sec_nxt = sec_r | cmd_data_i[2:0];
							if (prog_mode_i)
								sec_nxt = cmd_data_i[2:0] | {1'b0, sec_r[`FBR_SEC_CHPERA], 1'b0};
							st_nxt = FBR_ST_DONE;
						end
						// RULE9 boot swap, taken in prog mode on either variant and in self mode on the large variant
						FBR_CMD_SWAP: begin
							swap_nxt = ~swap_r;
							st_nxt = FBR_ST_DONE;
						end
						default: st_nxt = FBR_ST_IDLE;
					endcase
					ref_nxt = (st_nxt == FBR_ST_IDLE);
				end else if (cmd_valid_i) begin
					ref_nxt = 1'b1;
				end
			end
			FBR_ST_BUSY: begin
				// counter only counts down here, though a command refused in idle after lvl_ok still reloads it
				cnt_nxt = cnt_r - `FBR_CNT_STEP;
				if (last_cyc)
					st_nxt = FBR_ST_DONE;
			end
			FBR_ST_DONE: st_nxt = FBR_ST_IDLE;
			default: st_nxt = FBR_ST_IDLE;
		endcase
	end
	// ****************************************
	// fetch port
	// ****************************************
	always_comb begin
		// RULE1 one word of four bytes per clock
		fd_nxt = mem_r[fetch_addr_i[AW-1:0] ^ (swap_r ? AW'(BLK_WORDS) : AW'(0))];
		// RULE4 fetch blocked during a self-programming operation
		// programmer-driven operations never block, the programmer owns the core then
		ok_nxt = fetch_req_i & ~(st_r != FBR_ST_IDLE && self_r);
	end
	// ****************************************
	// next values of the registered outputs
	// ****************************************
	// decoded from the next state so every output leaves a flop directly
	always_comb begin
		busy_nxt = (st_nxt == FBR_ST_BUSY);
		done_nxt = (st_nxt == FBR_ST_DONE);
		// RULE5 interrupts acknowledged in every state
		ack_nxt  = irq_req_i;
		// zero when blocked, so a stale word never looks like a fetch
		fdo_nxt  = ok_nxt ? fd_nxt : '0;
		// RULE10 chip-erase lock is never cleared by a command, only by reset
		lock_nxt = sec_nxt | {1'b0, sec_r[`FBR_SEC_CHPERA], 1'b0};
	end
	// ****************************************
	// sequencer state registers
	// ****************************************
	// security and swap reset to open; a real part would load them from the array
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= FBR_ST_IDLE;
			op_r <= FBR_CMD_NONE;
			ad_r <= '0;
			wd_r <= '0;
			cnt_r <= '0;
			sec_r <= '0;
			swap_r <= 1'b0;
			self_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			ad_r <= ad_nxt;
			wd_r <= wd_nxt;
			cnt_r <= cnt_nxt;
			sec_r <= lock_nxt;
			swap_r <= swap_nxt;
			self_r <= self_nxt;
		end
	end
	// ****************************************
	// output registers
	// ****************************************
	// only registers here, all decoding sits in the combinational blocks above
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			refused_o <= 1'b0;
			fetch_ok_o <= 1'b0;
			fetch_data_o <= '0;
			irq_ack_o <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			refused_o <= ref_nxt;
			fetch_ok_o <= ok_nxt;
			fetch_data_o <= fdo_nxt;
			irq_ack_o <= ack_nxt;
			busy_o <= busy_nxt;
			done_o <= done_nxt;
		end
	end
	// ****************************************
	// array update at end of operation
	// ****************************************
	// RULE2 block erase acts on a whole block, program on one word; RULE3 chip erase hits all
	// array has no reset: contents stay unknown until the first erase
	// the whole operation lands on its last cycle, so an aborted one changes nothing
	always_ff @(posedge clk_i) begin
		if (last_cyc) begin
			for (int i = 0; i < BLOCKS * BLK_WORDS; i++) begin
				if (op_r == FBR_CMD_CERA
					|| (op_r == FBR_CMD_BERA && (i / BLK_WORDS) == int'(ad_r[AW-1:AW-BW])))
					mem_r[i] <= `FBR_ERASED_WORD;
				else if (op_r == FBR_CMD_PROG && i == int'(ad_r))
					mem_r[i] <= mem_r[i] & wd_r;
			end
		end
	end
	assign sec_o  = sec_r;
	assign swap_o = swap_r;
endmodule : fbr_ctrl

// >>> verif/fbr_ctrl_asserts.sv
`timescale 1ns/1ps
// ****
// port checks of the sequencer
// ****
module fbr_ctrl_asserts (
	input wire logic              clk_i,
	input wire logic              rstn_i,
	input wire logic              fetch_req_i,
	input wire logic              fetch_ok_o,
	input wire logic              prog_mode_i,
	input wire logic              self_mode_i,
	input wire logic              cmd_valid_i,
	input wire fbr_pkg::fbr_cmd_t cmd_i,
	input wire logic              irq_req_i,
	input wire logic              irq_ack_o,
	input wire logic              busy_o,
	input wire logic              done_o,
	input wire logic              refused_o,
	input wire logic [2:0]        sec_o
);
	import fbr_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// command taken while idle
	sequence s_take(c, m);
		cmd_valid_i && !busy_o && !done_o && cmd_i == c && m;
	endsequence
	// sixteen busy cycles then the done pulse
	sequence s_op;
		busy_o [*8] ##1 busy_o [*8] ##1 (done_o && !busy_o);
	endsequence
	property p_fetch; fetch_req_i && !cmd_valid_i && !busy_o && !done_o |=> fetch_ok_o; endproperty
	property p_nofetch; !fetch_req_i |=> !fetch_ok_o; endproperty
	property p_block; busy_o && self_mode_i && !prog_mode_i |=> !fetch_ok_o; endproperty
	property p_irq; 1'b1 |=> irq_ack_o == $past(irq_req_i); endproperty
	property p_prog; s_take(FBR_CMD_PROG, prog_mode_i && !sec_o[2]) |=> s_op; endproperty
	property p_cself; s_take(FBR_CMD_CERA, !prog_mode_i) |=> refused_o && !busy_o; endproperty
	property p_csec; s_take(FBR_CMD_CERA, sec_o[1]) |=> refused_o; endproperty
	property p_perm; sec_o[1] |=> sec_o[1]; endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch not answered");
	a_nofetch: assert property (p_nofetch)
		else $error("fetch answered unasked");
	a_block: assert property (p_block)
		else $error("fetch served in self rewrite");
	a_irq: assert property (p_irq)
		else $error("interrupt not taken");
	a_prog: assert property (p_prog)
		else $error("program timing wrong");
	a_cself: assert property (p_cself)
		else $error("chip erase outside prog mode");
	a_csec: assert property (p_csec)
		else $error("locked chip erase ran");
	a_perm: assert property (p_perm)
		else $error("chip erase lock cleared");
endmodule : fbr_ctrl_asserts
bind fbr_ctrl fbr_ctrl_asserts u_chk (.*);

// >>> verif/fbr_prog_model.sv
`timescale 1ns/1ps
// ****
// external programmer on the serial side
// ****
module fbr_prog_model (
	input wire logic          clk_i,
	input wire logic          done_o,
	input wire logic          refused_o,
	output logic              cmd_valid_i,
	output fbr_pkg::fbr_cmd_t cmd_i,
	output logic [15:0]       cmd_addr_i,
	output logic [31:0]       cmd_data_i
);
	import fbr_pkg::*;
	initial begin
		cmd_valid_i = 1'b0;
		cmd_i = FBR_CMD_NONE;
		cmd_addr_i = 16'h0000;
		cmd_data_i = 32'h00000000;
	end
	// one command, then wait for its answer
	task automatic issue(input fbr_cmd_t c, input logic [15:0] a,
			input logic [31:0] d, output logic r);
		int n;
		@(posedge clk_i);
		cmd_valid_i <= 1'b1;
		cmd_i <= c;
		cmd_addr_i <= a;
		cmd_data_i <= d;
		@(posedge clk_i);
		cmd_valid_i <= 1'b0;
		cmd_i <= FBR_CMD_NONE;
		cmd_addr_i <= ~a; // released lines carry junk
		cmd_data_i <= ~d;
		for (n = 0; n < 40 && !(done_o | refused_o); n++)
			@(negedge clk_i);
		r = refused_o;
	endtask : issue
endmodule : fbr_prog_model

// >>> verif/test_fbr_ctrl.sv
`timescale 1ns/1ps
// ****
// bench of the rewrite sequencer
// ****
module test_fbr_ctrl;
	import fbr_pkg::*;
	logic clk_i, rstn_i, fetch_req_i, fetch_ok_o, prog_mode_i, self_mode_i, r;
	logic cmd_valid_i, irq_req_i, irq_ack_o, busy_o, done_o, refused_o, swap_o;
	logic [15:0] fetch_addr_i, cmd_addr_i;
	logic [31:0] fetch_data_o, cmd_data_i;
	logic [2:0] sec_o;
	fbr_cmd_t cmd_i;
	int err_count = 0;
	int cmp_count = 0;
	fbr_ctrl dut (.*);
	fbr_prog_model pm (.*);
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task chk(input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task fx(input logic [15:0] a);
		@(posedge clk_i);
		fetch_req_i <= 1'b1;
		fetch_addr_i <= a;
		@(posedge clk_i);
		fetch_req_i <= 1'b0;
		@(negedge clk_i);
	endtask : fx
	task t_prog;
		@(posedge clk_i);
		prog_mode_i <= 1'b1;
		pm.issue(FBR_CMD_CERA, 16'h0000, 32'h0, r);
		fx(16'h0001);
		chk(fetch_ok_o, 1'b1);
		chk(fetch_data_o, 32'hFFFFFFFF);
		pm.issue(FBR_CMD_PROG, 16'h0011, 32'h0000A5A5, r);
		pm.issue(FBR_CMD_BERA, 16'h0000, 32'h0, r);
		fx(16'h0011);
		chk(fetch_data_o, 32'h0000A5A5);
		$display("prog test done");
	endtask : t_prog
	task t_self;
		@(posedge clk_i);
		prog_mode_i <= 1'b0;
		self_mode_i <= 1'b1;
		irq_req_i <= 1'b1;
		fork
			pm.issue(FBR_CMD_BERA, 16'h0020, 32'h0, r);
			begin
				repeat (4) @(posedge clk_i);
				fx(16'h0011);
				chk(fetch_ok_o, 1'b0);
				chk(irq_ack_o, 1'b1);
			end
		join
		pm.issue(FBR_CMD_CERA, 16'h0000, 32'h0, r);
		chk(r, 1'b1);
		pm.issue(FBR_CMD_SWAP, 16'h0000, 32'h1, r);
		chk(swap_o, 1'b1);
		fx(16'h0001);
		chk(fetch_data_o, 32'h0000A5A5);
		$display("self test done");
	endtask : t_self
	task t_sec;
		@(posedge clk_i);
		prog_mode_i <= 1'b1;
		self_mode_i <= 1'b0;
		irq_req_i <= 1'b0;
		pm.issue(FBR_CMD_SECUR, 16'h0000, 32'h2, r);
		chk(sec_o, 3'h2);
		pm.issue(FBR_CMD_CERA, 16'h0000, 32'h0, r);
		chk(r, 1'b1);
		pm.issue(FBR_CMD_SECUR, 16'h0000, 32'h0, r);
		chk(sec_o, 3'h2);
		$display("security test done");
	endtask : t_sec
	task results;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	// whole run needs a little under a hundred cycles
	initial begin
		repeat (3000) @(posedge clk_i);
		err_count++;
		results;
	end
	initial begin
		rstn_i = 1'b0;
		fetch_req_i = 1'b0;
		fetch_addr_i = 16'h0000;
		prog_mode_i = 1'b0;
		self_mode_i = 1'b0;
		irq_req_i = 1'b0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_prog;
		t_self;
		t_sec;
		results;
	end
endmodule : test_fbr_ctrl
